/* File: logic/dmm_pkg.sv */
// constants, types and address classes for the data memory map
// Notes on behaviour
// - general storage starts at 000h, grows upward
// - general storage never cleared by any reset
// - special function area is static storage F80h-FFFh, except bank select FE0h, which reset clears
// - unassigned special function addresses read zero
// - large-variant-only registers read zero on small variant
// - indirect access addresses have no storage behind
// - 12-bit address, 16 banks of 256 bytes
// - fast window: bank0 00h-7Fh plus bank15 80h-FFh
package dmm_pkg;

  localparam int ADDR_W      = 12;
  localparam int DATA_W      = 8;
  localparam int BANK_W      = 4;
  localparam int OFFS_W      = 8;
  localparam int AREA_IDX_W    = 7;
  localparam int AREA_DEPTH    = 128;
  localparam int STORE_MAX     = 3968;
  localparam int STORE_DEFAULT = 3584;

  localparam logic [ADDR_W-1:0] STORE_BASE        = 12'h000;
  localparam logic [ADDR_W-1:0] AREA_BASE         = 12'hf80;
  localparam logic [ADDR_W-1:0] AREA_TOP          = 12'hfff;
  localparam logic [BANK_W-1:0] WINDOW_LOW_BANK   = 4'h0;
  localparam logic [BANK_W-1:0] WINDOW_HIGH_BANK  = 4'hf;
  localparam int                WINDOW_SPLIT_BIT  = 7;
  localparam logic [DATA_W-1:0] READ_ZERO         = 8'h00;
  localparam logic [BANK_W-1:0] BANK_RESET        = 4'h0;
  localparam logic [BANK_W-1:0] BANK_PAD          = 4'h0;

  // core register offsets
  localparam logic [ADDR_W-1:0] STATUS_FLAGS_OFFS        = 12'hfd8;
  localparam logic [ADDR_W-1:0] PTR2_LOW_OFFS            = 12'hfd9;
  localparam logic [ADDR_W-1:0] PTR2_HIGH_OFFS           = 12'hfda;
  localparam logic [ADDR_W-1:0] PTR2_OFFSET_BY_W_OFFS    = 12'hfdb;
  localparam logic [ADDR_W-1:0] PTR2_PREINCREMENT_OFFS   = 12'hfdc;
  localparam logic [ADDR_W-1:0] PTR2_POSTDECREMENT_OFFS  = 12'hfdd;
  localparam logic [ADDR_W-1:0] PTR2_POSTINCREMENT_OFFS  = 12'hfde;
  localparam logic [ADDR_W-1:0] PTR2_INDIRECT_OFFS       = 12'hfdf;
  localparam logic [ADDR_W-1:0] BANK_SELECT_OFFS         = 12'hfe0;
  localparam logic [ADDR_W-1:0] PTR1_LOW_OFFS            = 12'hfe1;
  localparam logic [ADDR_W-1:0] PTR1_HIGH_OFFS           = 12'hfe2;
  localparam logic [ADDR_W-1:0] PTR1_OFFSET_BY_W_OFFS    = 12'hfe3;
  localparam logic [ADDR_W-1:0] PTR1_PREINCREMENT_OFFS   = 12'hfe4;
  localparam logic [ADDR_W-1:0] PTR1_POSTDECREMENT_OFFS  = 12'hfe5;
  localparam logic [ADDR_W-1:0] PTR1_POSTINCREMENT_OFFS  = 12'hfe6;
  localparam logic [ADDR_W-1:0] PTR1_INDIRECT_OFFS       = 12'hfe7;
  localparam logic [ADDR_W-1:0] WORKING_REGISTER_OFFS    = 12'hfe8;
  localparam logic [ADDR_W-1:0] PTR0_LOW_OFFS            = 12'hfe9;
  localparam logic [ADDR_W-1:0] PTR0_HIGH_OFFS           = 12'hfea;
  localparam logic [ADDR_W-1:0] PTR0_OFFSET_BY_W_OFFS    = 12'hfeb;
  localparam logic [ADDR_W-1:0] PTR0_PREINCREMENT_OFFS   = 12'hfec;
  localparam logic [ADDR_W-1:0] PTR0_POSTDECREMENT_OFFS  = 12'hfed;
  localparam logic [ADDR_W-1:0] PTR0_POSTINCREMENT_OFFS  = 12'hfee;
  localparam logic [ADDR_W-1:0] PTR0_INDIRECT_OFFS       = 12'hfef;
  localparam logic [ADDR_W-1:0] INTERRUPT_CONTROL_3_OFFS = 12'hff0;
  localparam logic [ADDR_W-1:0] INTERRUPT_CONTROL_2_OFFS = 12'hff1;
  localparam logic [ADDR_W-1:0] INTERRUPT_CONTROL_1_OFFS = 12'hff2;
  localparam logic [ADDR_W-1:0] PRODUCT_LOW_OFFS         = 12'hff3;
  localparam logic [ADDR_W-1:0] PRODUCT_HIGH_OFFS        = 12'hff4;
  localparam logic [ADDR_W-1:0] TABLE_LATCH_OFFS         = 12'hff5;
  localparam logic [ADDR_W-1:0] TABLE_POINTER_LOW_OFFS   = 12'hff6;
  localparam logic [ADDR_W-1:0] TABLE_POINTER_HIGH_OFFS  = 12'hff7;
  localparam logic [ADDR_W-1:0] TABLE_POINTER_UPPER_OFFS = 12'hff8;
  localparam logic [ADDR_W-1:0] PROGRAM_COUNTER_LOW_OFFS = 12'hff9;
  localparam logic [ADDR_W-1:0] PC_LATCH_HIGH_OFFS       = 12'hffa;
  localparam logic [ADDR_W-1:0] PC_LATCH_UPPER_OFFS      = 12'hffb;
  localparam logic [ADDR_W-1:0] RETURN_STACK_PTR_OFFS    = 12'hffc;
  localparam logic [ADDR_W-1:0] STACK_TOP_LOW_OFFS       = 12'hffd;
  localparam logic [ADDR_W-1:0] STACK_TOP_HIGH_OFFS      = 12'hffe;
  localparam logic [ADDR_W-1:0] STACK_TOP_UPPER_OFFS     = 12'hfff;

  // locations in the special function area with nothing assigned
  localparam int UNUSED_N = 15;
  localparam logic [ADDR_W-1:0] UNUSED_ADDRS [UNUSED_N] = '{
    12'hfd4, 12'hfb9, 12'hf9c, 12'hf9a, 12'hf99, 12'hf98, 12'hf97, 12'hf91,
    12'hf90, 12'hf8f, 12'hf8e, 12'hf88, 12'hf87, 12'hf86, 12'hf85};

  // locations present only on the larger pin-count variant
  localparam int LARGE_N = 11;
  localparam logic [ADDR_W-1:0] LARGE_ADDRS [LARGE_N] = '{
    12'hfbc, 12'hfbb, 12'hfba, 12'hfb6, 12'hfb5, 12'hf96, 12'hf95, 12'hf8d,
    12'hf8c, 12'hf84, 12'hf83};

  // not physical: indirect ports and the unlock sequencing location
  localparam int NOSTORE_N = 16;
  localparam logic [ADDR_W-1:0] NOSTORE_ADDRS [NOSTORE_N] = '{
    PTR0_INDIRECT_OFFS, PTR0_POSTINCREMENT_OFFS, PTR0_POSTDECREMENT_OFFS,
    PTR0_PREINCREMENT_OFFS, PTR0_OFFSET_BY_W_OFFS,
    PTR1_INDIRECT_OFFS, PTR1_POSTINCREMENT_OFFS, PTR1_POSTDECREMENT_OFFS,
    PTR1_PREINCREMENT_OFFS, PTR1_OFFSET_BY_W_OFFS,
    PTR2_INDIRECT_OFFS, PTR2_POSTINCREMENT_OFFS, PTR2_POSTDECREMENT_OFFS,
    PTR2_PREINCREMENT_OFFS, PTR2_OFFSET_BY_W_OFFS, 12'hfa7};

  typedef enum logic [1:0] {
    MODE_FULL   = 2'h0,
    MODE_BANKED = 2'h1,
    MODE_WINDOW = 2'h2
  } dmm_mode_t;

  typedef enum logic [2:0] {
    LOC_NONE    = 3'h0,
    LOC_STORE   = 3'h1,
    LOC_AREA    = 3'h2,
    LOC_BANKSEL = 3'h3,
    LOC_ZERO    = 3'h4
  } dmm_loc_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    dmm_loc_t          loc;
  } dmm_decode_t;

endpackage : dmm_pkg

/* File: logic/dmm_data_map.sv */
// data memory address decode, general storage and special function storage
`timescale 1ns/1ps
module dmm_data_map #(
  parameter int   STORE_BYTES   = dmm_pkg::STORE_DEFAULT,
  parameter logic LARGE_VARIANT = 1'b1
) (
  input  wire logic                        CLK,
  input  wire logic                        RESET_N,
  input  wire logic                        RD_EN,
  input  wire logic                        WR_EN,
  input  wire logic [1:0]                  ADDR_MODE,
  input  wire logic [dmm_pkg::ADDR_W-1:0]  ADDR,
  input  wire logic [dmm_pkg::DATA_W-1:0]  WDATA,
  output logic      [dmm_pkg::DATA_W-1:0]  RDATA,
  output logic                             RVALID,
  output logic      [dmm_pkg::BANK_W-1:0]  BANK
);

  // storage may not reach into the special function area
  if (STORE_BYTES < 1 || STORE_BYTES > dmm_pkg::STORE_MAX) begin : g_bad_size
    $error("STORE_BYTES must lie between 1 and the base of the special area");
  end

  ////////////////////////////////////////////////////////////////////////////
  // address formation

  dmm_pkg::dmm_mode_t              mode;
  logic [dmm_pkg::BANK_W-1:0]      bank_q;
  logic [dmm_pkg::BANK_W-1:0]      bank_d;
  logic [dmm_pkg::BANK_W-1:0]      window_bank;
  logic [dmm_pkg::ADDR_W-1:0]      eff_addr;
  dmm_pkg::dmm_decode_t            dec;

  assign mode        = dmm_pkg::dmm_mode_t'(ADDR_MODE);
  // window: low half from bank 0, high half from bank 15
  assign window_bank = ADDR[dmm_pkg::WINDOW_SPLIT_BIT] ? dmm_pkg::WINDOW_HIGH_BANK
                                                       : dmm_pkg::WINDOW_LOW_BANK;
  // 12 bits: 4-bit bank over 8-bit offset
  assign eff_addr = (mode == dmm_pkg::MODE_BANKED) ?
                      {bank_q, ADDR[dmm_pkg::OFFS_W-1:0]} :
                    (mode == dmm_pkg::MODE_WINDOW) ?
                      {window_bank, ADDR[dmm_pkg::OFFS_W-1:0]} :
                      ADDR;

  ////////////////////////////////////////////////////////////////////////////
  // location classification

  wire [dmm_pkg::UNUSED_N-1:0]  unused_hit;
  wire [dmm_pkg::LARGE_N-1:0]   large_hit;
  wire [dmm_pkg::NOSTORE_N-1:0] nostore_hit;

  // one comparator per listed location, all in parallel
  for (genvar i = 0; i < dmm_pkg::UNUSED_N; i++) begin : g_unused
    assign unused_hit[i] = (eff_addr == dmm_pkg::UNUSED_ADDRS[i]);
  end
  for (genvar i = 0; i < dmm_pkg::LARGE_N; i++) begin : g_large
    assign large_hit[i] = (eff_addr == dmm_pkg::LARGE_ADDRS[i]);
  end
  for (genvar i = 0; i < dmm_pkg::NOSTORE_N; i++) begin : g_nostore
    assign nostore_hit[i] = (eff_addr == dmm_pkg::NOSTORE_ADDRS[i]);
  end

  wire in_store   = (eff_addr >= dmm_pkg::STORE_BASE) &&
                    (int'(eff_addr) < STORE_BYTES);
  wire in_area    = (eff_addr >= dmm_pkg::AREA_BASE);
  wire is_unused  = |unused_hit;
  wire is_large   = |large_hit;
  wire is_nostore = |nostore_hit;
  wire is_banksel = (eff_addr == dmm_pkg::BANK_SELECT_OFFS);

  assign dec.addr = eff_addr;
  assign dec.loc  = in_store ? dmm_pkg::LOC_STORE :
                    !in_area ? dmm_pkg::LOC_NONE :
                    (is_unused || is_nostore) ? dmm_pkg::LOC_ZERO :
                    (is_large && !LARGE_VARIANT) ? dmm_pkg::LOC_ZERO :
                    is_banksel ? dmm_pkg::LOC_BANKSEL :
                    dmm_pkg::LOC_AREA;

  wire [dmm_pkg::AREA_IDX_W-1:0] area_idx = dec.addr[dmm_pkg::AREA_IDX_W-1:0];

  // only real storage takes a write; everything else is dropped
  wire store_we = WR_EN && (dec.loc == dmm_pkg::LOC_STORE);
  wire area_we  = WR_EN && (dec.loc == dmm_pkg::LOC_AREA);
  wire bank_we  = WR_EN && (dec.loc == dmm_pkg::LOC_BANKSEL);

  ////////////////////////////////////////////////////////////////////////////
  // storage arrays: no reset, contents survive every reset

  logic [dmm_pkg::DATA_W-1:0] store_mem [STORE_BYTES];
  logic [dmm_pkg::DATA_W-1:0] area_mem  [dmm_pkg::AREA_DEPTH];

  always_ff @(posedge CLK) begin
    if (store_we) begin
      store_mem[dec.addr] <= WDATA;
    end
  end

  always_ff @(posedge CLK) begin
    if (area_we) begin
      area_mem[area_idx] <= WDATA;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bank pointer: low nibble only, upper bits read zero

  assign bank_d = bank_we ? WDATA[dmm_pkg::BANK_W-1:0] : bank_q;

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      bank_q <= dmm_pkg::BANK_RESET;
    end else begin
      bank_q <= bank_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path, one cycle latency

  logic [dmm_pkg::DATA_W-1:0] rdata_d;
  logic [dmm_pkg::DATA_W-1:0] rdata_q;
  logic                       rvalid_q;

  // arrays are read before a same-cycle write lands: read returns old data
  assign rdata_d = (dec.loc == dmm_pkg::LOC_STORE)   ? store_mem[dec.addr] :
                   (dec.loc == dmm_pkg::LOC_AREA)    ? area_mem[area_idx] :
                   (dec.loc == dmm_pkg::LOC_BANKSEL) ? {dmm_pkg::BANK_PAD, bank_q} :
                   dmm_pkg::READ_ZERO;

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      rdata_q  <= dmm_pkg::READ_ZERO;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= RD_EN;
      if (RD_EN) begin
        rdata_q <= rdata_d;
      end
    end
  end

  assign RDATA  = rdata_q;
  assign RVALID = rvalid_q;
  assign BANK   = bank_q;

endmodule : dmm_data_map

/* File: test/dmm_checker.sv */
// concurrent checks on the data map ports
`timescale 1ns/1ps
module dmm_checker #(
  parameter logic LARGE_VARIANT = 1'b1
) (
  input wire logic        CLK,
  input wire logic        RESET_N,
  input wire logic        RD_EN,
  input wire logic        WR_EN,
  input wire logic [1:0]  ADDR_MODE,
  input wire logic [11:0] ADDR,
  input wire logic [7:0]  WDATA,
  input wire logic [7:0]  RDATA,
  input wire logic        RVALID,
  input wire logic [3:0]  BANK
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  wire full_rd = RD_EN && ADDR_MODE == 2'h0;
  sequence s_zero; RVALID && RDATA == 8'h00; endsequence
  a_read_answer: assert property (RD_EN |=> RVALID) else $error("read unanswered");
  a_no_spurious: assert property (!RD_EN |=> !RVALID) else $error("stray valid");
  a_rdata_held: assert property (!RD_EN |=> $stable(RDATA)) else $error("rdata moved");
  a_bank_written: assert property (WR_EN && ADDR_MODE == 2'h0 && ADDR == 12'hfe0
    |=> BANK == $past(WDATA[3:0])) else $error("bank not loaded");
  a_bank_kept: assert property (!WR_EN |=> $stable(BANK)) else $error("bank moved");
  a_bank_reads_low: assert property (full_rd && ADDR == 12'hfe0
    |=> RDATA == {4'h0, $past(BANK)}) else $error("bank readback wrong");
  a_unused_zero: assert property (full_rd && ADDR inside {12'hfd4, 12'hfb9, 12'hf9c}
    |=> s_zero) else $error("unused not zero");
  a_indirect_zero: assert property (full_rd && ADDR inside {12'hfef, 12'hfe7, 12'hfdf}
    |=> s_zero) else $error("indirect not zero");
  a_small_absent: assert property (!LARGE_VARIANT && full_rd
    && ADDR inside {12'hfbc, 12'hf96, 12'hf83} |=> s_zero) else $error("absent not zero");
endmodule : dmm_checker
////////////////////////////////////////////////////////////////////////////////
bind dmm_data_map dmm_checker #(.LARGE_VARIANT(LARGE_VARIANT)) u_chk (.CLK(CLK),
  .RESET_N(RESET_N), .RD_EN(RD_EN), .WR_EN(WR_EN), .ADDR_MODE(ADDR_MODE), .ADDR(ADDR),
  .WDATA(WDATA), .RDATA(RDATA), .RVALID(RVALID), .BANK(BANK));

/* File: test/dmm_core_model.sv */
// processor core model issuing data memory reads and writes
`timescale 1ns/1ps
module dmm_core_model (
  input  wire logic        CLK,
  output logic             RD_EN,
  output logic             WR_EN,
  output logic [1:0]       ADDR_MODE,
  output logic [11:0]      ADDR,
  output logic [7:0]       WDATA,
  input  wire logic [7:0]  RDATA,
  input  wire logic        RVALID
);
  initial begin
    RD_EN = 1'b0;
    WR_EN = 1'b0;
    ADDR_MODE = 2'h0;
    ADDR = 12'h000;
    WDATA = 8'h00;
  end
  task automatic req(input logic w, input logic [1:0] m, input logic [11:0] a,
                     input logic [7:0] d);
    @(posedge CLK);
    #1;
    RD_EN = !w;
    WR_EN = w;
    ADDR_MODE = m;
    ADDR = a;
    WDATA = d;
    @(posedge CLK);
    #1;
    RD_EN = 1'b0;
    WR_EN = 1'b0;
    // idle lines toggle so a stale value never passes for a driven one
    ADDR = ~a;
    WDATA = ~d;
  endtask : req
  // answer is due on the taking edge itself and is sampled 1 ns after it
  task automatic rd(input logic [1:0] m, input logic [11:0] a, output logic [7:0] q,
                    output logic ok);
    req(1'b0, m, a, 8'h00);
    ok = (RVALID === 1'b1);
    q = RDATA;
  endtask : rd
endmodule : dmm_core_model

/* File: test/tb_top.sv */
// self-checking bench for the data memory map
`timescale 1ns/1ps
module tb_top;
  logic clk, reset_n, rd_en, wr_en, rvalid, ok;
  logic [1:0] addr_mode;
  logic [11:0] addr;
  logic [7:0] wdata, rdata, s_rdata, q;
  logic [3:0] bank;
  int bad_count, compares;
  dmm_core_model core (.CLK(clk), .RD_EN(rd_en), .WR_EN(wr_en), .ADDR_MODE(addr_mode),
    .ADDR(addr), .WDATA(wdata), .RDATA(rdata), .RVALID(rvalid));
  dmm_data_map u_dut (.CLK(clk), .RESET_N(reset_n), .RD_EN(rd_en), .WR_EN(wr_en),
    .ADDR_MODE(addr_mode), .ADDR(addr), .WDATA(wdata), .RDATA(rdata), .RVALID(rvalid),
    .BANK(bank));
  // small variant sees the same traffic; only its read data is compared
  dmm_data_map #(.LARGE_VARIANT(1'b0)) u_small (.CLK(clk), .RESET_N(reset_n),
    .RD_EN(rd_en), .WR_EN(wr_en), .ADDR_MODE(addr_mode), .ADDR(addr), .WDATA(wdata),
    .RDATA(s_rdata), .RVALID(), .BANK());
  always #10 clk = ~clk;
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic rchk(input logic [1:0] m, input logic [11:0] a, input logic [7:0] exp);
    core.rd(m, a, q, ok);
    check({7'h00, ok}, 8'h01);
    check(q, exp);
  endtask : rchk
  task automatic conclude();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (100000) @(posedge clk);
    bad_count++;
    conclude();
  end
  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    bad_count = 0;
    compares = 0;
    repeat (8) @(posedge clk);
    #1 reset_n = 1'b1;
    check(rdata, 8'h00);
    check({4'h0, bank}, 8'h00);
    core.req(1'b1, 2'h0, 12'h000, 8'h5a);
    core.req(1'b1, 2'h0, 12'hdff, 8'ha5);
    core.req(1'b1, 2'h0, 12'hf80, 8'h3c);
    core.req(1'b1, 2'h0, 12'hfff, 8'hc3);
    rchk(2'h0, 12'hf80, 8'h3c);
    rchk(2'h0, 12'hfff, 8'hc3);
    core.req(1'b1, 2'h0, 12'hfe0, 8'hff);
    check({4'h0, bank}, 8'h0f);
    rchk(2'h0, 12'hfe0, 8'h0f);
    // second reset in mid-run: general storage must come through it
    @(posedge clk);
    #1 reset_n = 1'b0;
    repeat (2) @(posedge clk);
    #1 reset_n = 1'b1;
    check({4'h0, bank}, 8'h00);
    rchk(2'h0, 12'h000, 8'h5a);
    rchk(2'h0, 12'hdff, 8'ha5);
    for (int i = 0; i < dmm_pkg::UNUSED_N; i++) begin
      core.req(1'b1, 2'h0, dmm_pkg::UNUSED_ADDRS[i], 8'hff);
      rchk(2'h0, dmm_pkg::UNUSED_ADDRS[i], 8'h00);
    end
    check({4'h0, bank}, 8'h00);
    for (int i = 0; i < dmm_pkg::NOSTORE_N; i++) begin
      core.req(1'b1, 2'h0, dmm_pkg::NOSTORE_ADDRS[i], 8'he7);
      rchk(2'h0, dmm_pkg::NOSTORE_ADDRS[i], 8'h00);
    end
    for (int i = 0; i < dmm_pkg::LARGE_N; i++) begin
      core.req(1'b1, 2'h0, dmm_pkg::LARGE_ADDRS[i], 8'h81);
      rchk(2'h0, dmm_pkg::LARGE_ADDRS[i], 8'h81);
      check(s_rdata, 8'h00);
    end
    core.req(1'b1, 2'h0, 12'he00, 8'h99);
    rchk(2'h0, 12'he00, 8'h00);
    rchk(2'h0, 12'h000, 8'h5a);
    core.req(1'b1, 2'h0, 12'hfe0, 8'h03);
    core.req(1'b1, 2'h1, 12'h045, 8'h77);
    rchk(2'h0, 12'h345, 8'h77);
    rchk(2'h1, 12'hf45, 8'h77);
    rchk(2'h2, 12'h000, 8'h5a);
    rchk(2'h2, 12'h0ff, 8'hc3);
    rchk(2'h2, 12'h080, 8'h3c);
    core.req(1'b1, 2'h2, 12'h07f, 8'h11);
    rchk(2'h0, 12'h07f, 8'h11);
    rchk(2'h3, 12'hdff, 8'ha5);
    conclude();
  end
endmodule : tb_top
